// ### ckc_osc_model.sv
// Partner model: selected clock source and watchdog oscillator
`timescale 1ns/1ps
`default_nettype none
module ckc_osc_model #(
  parameter int SRC_HALF_NS = 80,
  parameter int WDT_HALF_NS = 320
) (
  output logic src_osc,
  output logic wdt_osc
);
  // resonator-grade source
  // Stable from its first cycle, so short counts are safe here only
  initial begin
    src_osc = 1'b0;
    forever #(SRC_HALF_NS) src_osc = ~src_osc;
  end
  // Free running, unrelated in phase to the core clock
  initial begin
    wdt_osc = 1'b0;
    forever #(WDT_HALF_NS) wdt_osc = ~wdt_osc;
  end
endmodule : ckc_osc_model
`default_nettype wire

// ### ckc_pkg.sv
// Constants, types and fuse decode for the clock source and start-up control
package ckc_pkg;

  // Register word indices on the Avalon slave
  localparam int unsigned CKC_ADDR_W = 2;
  localparam logic [1:0] CKC_REG_CTRL = 2'h0;
  localparam logic [1:0] CKC_REG_STATUS = 2'h1;
  localparam logic [1:0] CKC_REG_FUSE = 2'h2;

  // Control register fields
  localparam int unsigned CKC_CTRL_MODE_LSB = 0;
  localparam int unsigned CKC_CTRL_GO_BIT = 3;
  localparam int unsigned CKC_CTRL_INTEN_BIT = 4;

  // Status register fields
  localparam int unsigned CKC_ST_STATE_LSB = 0;
  localparam int unsigned CKC_ST_SRC_LSB = 4;
  localparam int unsigned CKC_ST_SWING_BIT = 7;
  localparam int unsigned CKC_ST_RANGE_LSB = 8;
  localparam int unsigned CKC_ST_GATE_LSB = 10;
  localparam int unsigned CKC_ST_RSTN_BIT = 15;

  // Fuse register fields
  localparam int unsigned CKC_FU_CLOCK_SOURCE_SELECT_FUSES_LSB = 0;
  localparam int unsigned CKC_FU_SUT_LSB = 4;
  localparam int unsigned CKC_FU_OPT_BIT = 6;

  // Fuse codes; a one is unprogrammed, a zero programmed
  localparam logic [3:0] CKC_CLOCK_SOURCE_SELECT_FUSES_XTAL_MIN = 4'hA;
  localparam logic [3:0] CKC_CLOCK_SOURCE_SELECT_FUSES_LOWF = 4'h9;
  localparam logic [3:0] CKC_CLOCK_SOURCE_SELECT_FUSES_RC_MIN = 4'h5;
  localparam logic [3:0] CKC_CLOCK_SOURCE_SELECT_FUSES_INTRC_MIN = 4'h1;
  localparam logic [3:0] CKC_CLOCK_SOURCE_SELECT_FUSES_EXTCLK = 4'h0;
  localparam logic [2:0] CKC_XTAL_RANGE_LO = 3'h5;
  localparam logic [2:0] CKC_XTAL_RANGE_MID = 3'h6;
  localparam logic [1:0] CKC_SUT_00 = 2'h0;
  localparam logic [1:0] CKC_SUT_01 = 2'h1;
  localparam logic [1:0] CKC_SUT_10 = 2'h2;
  localparam logic CKC_FUSE_PROGRAMMED = 1'b0;

  // Shipped fuse state
  localparam logic [3:0] CKC_CLOCK_SOURCE_SELECT_FUSES_SHIP = 4'h1;
  localparam logic [1:0] CKC_SUT_SHIP = 2'h2;
  localparam logic CKC_OPT_SHIP = 1'b1;

  // Start-up clock counts that stay below the parameter threshold
  localparam logic [15:0] CKC_SU_6CK = 16'h0006;
  localparam logic [15:0] CKC_SU_18CK = 16'h0012;
  localparam logic [15:0] CKC_SU_258CK = 16'h0102;
  localparam logic [15:0] CKC_SU_1KCK = 16'h0400;

  typedef enum logic [2:0] {
    CKC_SRC_XTAL = 3'h0,
    CKC_SRC_LOWF = 3'h1,
    CKC_SRC_EXTRC = 3'h2,
    CKC_SRC_INTRC = 3'h3,
    CKC_SRC_EXTCLK = 3'h4
  } ckc_src_e;

  typedef enum logic [2:0] {
    CKC_ST_FUSE = 3'h0,
    CKC_ST_RSTDLY = 3'h1,
    CKC_ST_STARTUP = 3'h2,
    CKC_ST_RUN = 3'h3,
    CKC_ST_SLEEP = 3'h4,
    CKC_ST_WAKE = 3'h5
  } ckc_state_e;

  typedef enum logic [2:0] {
    CKC_SLP_IDLE = 3'h0,
    CKC_SLP_ADCNR = 3'h1,
    CKC_SLP_PDOWN = 3'h2,
    CKC_SLP_PSAVE = 3'h3,
    CKC_SLP_STBY = 3'h6,
    CKC_SLP_XSTBY = 3'h7
  } ckc_sleep_e;

  typedef enum logic [1:0] {
    CKC_RD_NONE = 2'h0,
    CKC_RD_SHORT = 2'h1,
    CKC_RD_LONG = 2'h2
  } ckc_rdly_e;

  typedef struct packed {
    logic core;
    logic periph;
    logic flash;
    logic asy;
    logic conv;
  } ckc_gate_s;

  typedef struct packed {
    logic [3:0] clock_source_select_fuses;
    logic [1:0] startup_time_fuses;
    logic opt;
  } ckc_fuse_s;

  typedef struct packed {
    logic [15:0] su_ck;
    ckc_rdly_e rd;
  } ckc_timing_s;

  function automatic ckc_src_e ckc_decode_src(input logic [3:0] clock_source_select_fuses);
    if (clock_source_select_fuses >= CKC_CLOCK_SOURCE_SELECT_FUSES_XTAL_MIN) begin
      return CKC_SRC_XTAL;
    end else if (clock_source_select_fuses == CKC_CLOCK_SOURCE_SELECT_FUSES_LOWF) begin
      return CKC_SRC_LOWF;
    end else if (clock_source_select_fuses >= CKC_CLOCK_SOURCE_SELECT_FUSES_RC_MIN) begin
      return CKC_SRC_EXTRC;
    end else if (clock_source_select_fuses >= CKC_CLOCK_SOURCE_SELECT_FUSES_INTRC_MIN) begin
      return CKC_SRC_INTRC;
    end else begin
      return CKC_SRC_EXTCLK;
    end
  endfunction : ckc_decode_src

endpackage : ckc_pkg

// ### ckc_top.sv
// Clock source decode, start-up sequencing and clock domain gating
// Summary of operation
// - Core clock gated off when core halted
// - Peripheral clock feeds timers, serial, interrupts
// - Some external interrupts detected asynchronously
// - Two-wire address match works with peripherals stopped
// - Program memory clock follows core clock
// - Async timer clock kept during power-save
// - Converter clock runs in noise-reduction sleep while core, peripherals stopped
// - Sleep mode selects which clocks run
// - Decode four-bit clock source fuse field
// - Fuse one unprogrammed, zero programmed
// - Wake from deep sleep counts source cycles
// - Reset adds watchdog-timed delay
// - Reset delays are 4096 or 65536 cycles
// - Shipped fuses select internal RC, slow power
// - Crystal range from upper select bits, option
// - Option fuse selects full or reduced swing
// - Crystal 258 clocks with short or long delay
// - Crystal 1K clock start-up variants
// - Crystal 16K clock start-up variants
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ckc_top #(
  parameter int unsigned P_RST_SHORT = 4096,
  parameter int unsigned P_RST_LONG = 65536,
  parameter int unsigned P_SU_16K = 16384,
  parameter int unsigned P_SU_32K = 32768
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic [ckc_pkg::CKC_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [3:0] CLOCK_SOURCE_SELECT_FUSES,
  input wire logic [1:0] STARTUP_TIME_FUSES,
  input wire logic OSCILLATOR_OPTION_FUSE,
  input wire logic SOURCE_OSC_PIN,
  input wire logic WATCHDOG_OSC_PIN,
  input wire logic WAKE_PIN,
  input wire logic EXT_INT_PIN,
  input wire logic TWO_WIRE_ADDR_MATCH,
  output logic ASYNC_WAKE,
  output logic INTERNAL_RESET_N,
  output var ckc_pkg::ckc_gate_s CLOCK_ENABLES,
  output var ckc_pkg::ckc_src_e SOURCE_KIND,
  output logic FULL_SWING,
  output logic [1:0] OSC_RANGE
);

  localparam int unsigned NSYNC = 12;

  logic [NSYNC-1:0] meta_reg;
  logic [NSYNC-1:0] sync_reg;
  logic [1:0] osc_last_reg;
  logic src_tick;
  logic wdt_tick;
  logic wake_sync;
  ckc_pkg::ckc_fuse_s fuse_sync;
  ckc_pkg::ckc_fuse_s fuse_reg;
  ckc_pkg::ckc_state_e state_reg;
  ckc_pkg::ckc_state_e state_next;
  ckc_pkg::ckc_sleep_e mode_reg;
  logic int_en_reg;
  logic go_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [16:0] cnt_reg;
  logic [16:0] cnt_next;
  logic cnt_done;
  ckc_pkg::ckc_timing_s timing;
  ckc_pkg::ckc_gate_s gate;
  logic wr_ctrl;

  // Pins pass two flops; oscillators edge-detected after that
  // No reset here, so straps are already caught when reset lifts
  // and the edge detector never sees a false edge after reset
  always_ff @(posedge CLK) begin
    if (CE) begin
      meta_reg <= {CLOCK_SOURCE_SELECT_FUSES, STARTUP_TIME_FUSES, OSCILLATOR_OPTION_FUSE,
                   SOURCE_OSC_PIN, WATCHDOG_OSC_PIN, WAKE_PIN, EXT_INT_PIN,
                   TWO_WIRE_ADDR_MATCH};
      sync_reg <= meta_reg;
      osc_last_reg <= sync_reg[4:3];
    end
  end

  assign fuse_sync = sync_reg[11:5];
  assign src_tick = sync_reg[4] & ~osc_last_reg[1];
  assign wdt_tick = sync_reg[3] & ~osc_last_reg[0];
  // address match wakes only with peripherals stopped
  assign wake_sync = sync_reg[2] | (sync_reg[1] & int_en_reg) | (sync_reg[0] & ~gate.periph);

  // interrupt pin recognised without any clock
  assign ASYNC_WAKE = (EXT_INT_PIN & int_en_reg) | (TWO_WIRE_ADDR_MATCH & ~gate.periph);

  // shipped fuses hold until the strap is caught
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      fuse_reg <= '{clock_source_select_fuses: ckc_pkg::CKC_CLOCK_SOURCE_SELECT_FUSES_SHIP, startup_time_fuses: ckc_pkg::CKC_SUT_SHIP,
                    opt: ckc_pkg::CKC_OPT_SHIP};
    end else if (CE && state_reg == ckc_pkg::CKC_ST_FUSE) begin
      fuse_reg <= fuse_sync;
    end
  end

  // source kind from the select field
  assign SOURCE_KIND = ckc_pkg::ckc_decode_src(fuse_reg.clock_source_select_fuses);
  assign FULL_SWING = (fuse_reg.opt == ckc_pkg::CKC_FUSE_PROGRAMMED);

  // range only meaningful for the crystal source
  always_comb begin
    OSC_RANGE = 2'h0;
    if (SOURCE_KIND == ckc_pkg::CKC_SRC_XTAL) begin
      if (FULL_SWING) begin
        OSC_RANGE = 2'h3;
      end else if (fuse_reg.clock_source_select_fuses[3:1] == ckc_pkg::CKC_XTAL_RANGE_LO) begin
        OSC_RANGE = 2'h0;
      end else if (fuse_reg.clock_source_select_fuses[3:1] == ckc_pkg::CKC_XTAL_RANGE_MID) begin
        OSC_RANGE = 2'h1;
      end else begin
        OSC_RANGE = 2'h2;
      end
    end
  end

  // Start-up clocks and reset delay per source and timing fuses
  always_comb begin
    timing = '{su_ck: ckc_pkg::CKC_SU_6CK, rd: ckc_pkg::CKC_RD_LONG};
    case (SOURCE_KIND)
      ckc_pkg::CKC_SRC_XTAL: begin
        if (!fuse_reg.clock_source_select_fuses[0]) begin
          case (fuse_reg.startup_time_fuses)
            ckc_pkg::CKC_SUT_00: timing = '{ckc_pkg::CKC_SU_258CK, ckc_pkg::CKC_RD_SHORT};
            ckc_pkg::CKC_SUT_01: timing = '{ckc_pkg::CKC_SU_258CK, ckc_pkg::CKC_RD_LONG};
            ckc_pkg::CKC_SUT_10: timing = '{ckc_pkg::CKC_SU_1KCK, ckc_pkg::CKC_RD_NONE};
            default: timing = '{ckc_pkg::CKC_SU_1KCK, ckc_pkg::CKC_RD_SHORT};
          endcase
        end else begin
          case (fuse_reg.startup_time_fuses)
            ckc_pkg::CKC_SUT_00: timing = '{ckc_pkg::CKC_SU_1KCK, ckc_pkg::CKC_RD_LONG};
            ckc_pkg::CKC_SUT_01: timing = '{16'(P_SU_16K), ckc_pkg::CKC_RD_NONE};
            ckc_pkg::CKC_SUT_10: timing = '{16'(P_SU_16K), ckc_pkg::CKC_RD_SHORT};
            default: timing = '{16'(P_SU_16K), ckc_pkg::CKC_RD_LONG};
          endcase
        end
      end
      ckc_pkg::CKC_SRC_LOWF: begin
        case (fuse_reg.startup_time_fuses)
          ckc_pkg::CKC_SUT_00: timing = '{ckc_pkg::CKC_SU_1KCK, ckc_pkg::CKC_RD_SHORT};
          ckc_pkg::CKC_SUT_01: timing = '{ckc_pkg::CKC_SU_1KCK, ckc_pkg::CKC_RD_LONG};
          default: timing = '{16'(P_SU_32K), ckc_pkg::CKC_RD_LONG};
        endcase
      end
      ckc_pkg::CKC_SRC_EXTRC: begin
        case (fuse_reg.startup_time_fuses)
          ckc_pkg::CKC_SUT_00: timing = '{ckc_pkg::CKC_SU_18CK, ckc_pkg::CKC_RD_NONE};
          ckc_pkg::CKC_SUT_01: timing = '{ckc_pkg::CKC_SU_18CK, ckc_pkg::CKC_RD_SHORT};
          ckc_pkg::CKC_SUT_10: timing = '{ckc_pkg::CKC_SU_18CK, ckc_pkg::CKC_RD_LONG};
          default: timing = '{ckc_pkg::CKC_SU_6CK, ckc_pkg::CKC_RD_SHORT};
        endcase
      end
      default: begin
        // Internal RC and external clock; reserved code falls to long delay
        case (fuse_reg.startup_time_fuses)
          ckc_pkg::CKC_SUT_00: timing = '{ckc_pkg::CKC_SU_6CK, ckc_pkg::CKC_RD_NONE};
          ckc_pkg::CKC_SUT_01: timing = '{ckc_pkg::CKC_SU_6CK, ckc_pkg::CKC_RD_SHORT};
          default: timing = '{ckc_pkg::CKC_SU_6CK, ckc_pkg::CKC_RD_LONG};
        endcase
      end
    endcase
  end

  // watchdog cycle targets; start-up targets in source cycles
  always_comb begin
    cnt_done = 1'b0;
    case (state_reg)
      ckc_pkg::CKC_ST_RSTDLY: begin
        if (timing.rd == ckc_pkg::CKC_RD_NONE) begin
          cnt_done = 1'b1;
        end else if (timing.rd == ckc_pkg::CKC_RD_SHORT) begin
          cnt_done = wdt_tick && (cnt_reg == 17'(P_RST_SHORT - 1));
        end else begin
          cnt_done = wdt_tick && (cnt_reg == 17'(P_RST_LONG - 1));
        end
      end
      ckc_pkg::CKC_ST_STARTUP, ckc_pkg::CKC_ST_WAKE: begin
        cnt_done = src_tick && (cnt_reg == {1'b0, timing.su_ck - 16'h0001});
      end
      default: cnt_done = 1'b0;
    endcase
  end

  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ckc_pkg::CKC_ST_FUSE: state_next = ckc_pkg::CKC_ST_RSTDLY;
      // watchdog delay precedes the start-up count
      ckc_pkg::CKC_ST_RSTDLY: begin
        if (cnt_done) begin
          state_next = ckc_pkg::CKC_ST_STARTUP;
        end
      end
      // reset released only after both counts
      ckc_pkg::CKC_ST_STARTUP: begin
        if (cnt_done) begin
          state_next = ckc_pkg::CKC_ST_RUN;
        end
      end
      ckc_pkg::CKC_ST_RUN: begin
        if (go_reg) begin
          state_next = ckc_pkg::CKC_ST_SLEEP;
        end
      end
      // deep sleep wakes through a source count
      ckc_pkg::CKC_ST_SLEEP: begin
        if (wake_sync) begin
          if (mode_reg == ckc_pkg::CKC_SLP_PDOWN || mode_reg == ckc_pkg::CKC_SLP_PSAVE) begin
            state_next = ckc_pkg::CKC_ST_WAKE;
          end else begin
            state_next = ckc_pkg::CKC_ST_RUN;
          end
        end
      end
      ckc_pkg::CKC_ST_WAKE: begin
        if (cnt_done) begin
          state_next = ckc_pkg::CKC_ST_RUN;
        end
      end
      default: state_next = ckc_pkg::CKC_ST_FUSE;
    endcase
  end

  // Counter restarts on every state change
  always_comb begin
    cnt_next = cnt_reg;
    if (state_next != state_reg) begin
      cnt_next = 17'h00000;
    end else if ((state_reg == ckc_pkg::CKC_ST_RSTDLY && wdt_tick) ||
                 ((state_reg == ckc_pkg::CKC_ST_STARTUP || state_reg == ckc_pkg::CKC_ST_WAKE)
                  && src_tick)) begin
      cnt_next = cnt_reg + 17'h00001;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state_reg <= ckc_pkg::CKC_ST_FUSE;
      cnt_reg <= 17'h00000;
    end else if (CE) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  assign INTERNAL_RESET_N = (state_reg == ckc_pkg::CKC_ST_RUN) ||
                            (state_reg == ckc_pkg::CKC_ST_SLEEP) ||
                            (state_reg == ckc_pkg::CKC_ST_WAKE);

  // clock domains per state and sleep mode
  always_comb begin
    gate = '0;
    if (state_reg == ckc_pkg::CKC_ST_RUN) begin
      gate = '1;
    end else if (state_reg == ckc_pkg::CKC_ST_SLEEP) begin
      case (mode_reg)
        ckc_pkg::CKC_SLP_IDLE: gate = '{core: 1'b0, periph: 1'b1, flash: 1'b0, asy: 1'b1,
                                        conv: 1'b1};
        ckc_pkg::CKC_SLP_ADCNR: gate = '{core: 1'b0, periph: 1'b0, flash: 1'b0, asy: 1'b1,
                                         conv: 1'b1};
        ckc_pkg::CKC_SLP_PSAVE, ckc_pkg::CKC_SLP_XSTBY: gate = '{core: 1'b0, periph: 1'b0,
                                                                 flash: 1'b0, asy: 1'b1,
                                                                 conv: 1'b0};
        default: gate = '0;
      endcase
    end
  end

  // program memory clock tied to core clock
  assign CLOCK_ENABLES = '{core: gate.core, periph: gate.periph, flash: gate.core,
                           asy: gate.asy, conv: gate.conv};

  // Avalon slave; one wait state on every access
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
  assign wr_ctrl = AVS_WRITE && ack_reg && AVS_ADDRESS == ckc_pkg::CKC_REG_CTRL;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ack_reg <= 1'b0;
    end else if (CE) begin
      ack_reg <= (AVS_READ | AVS_WRITE) & ~ack_reg;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      mode_reg <= ckc_pkg::CKC_SLP_IDLE;
      int_en_reg <= 1'b0;
      go_reg <= 1'b0;
    end else if (CE) begin
      // Sleep request only honoured while awake
      go_reg <= wr_ctrl && AVS_WRITEDATA[ckc_pkg::CKC_CTRL_GO_BIT] &&
                state_reg == ckc_pkg::CKC_ST_RUN;
      if (wr_ctrl) begin
        mode_reg <= ckc_pkg::ckc_sleep_e'(AVS_WRITEDATA[ckc_pkg::CKC_CTRL_MODE_LSB +: 3]);
        int_en_reg <= AVS_WRITEDATA[ckc_pkg::CKC_CTRL_INTEN_BIT];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rdata_reg <= 32'h00000000;
    end else if (CE && AVS_READ && !ack_reg) begin
      rdata_reg <= 32'h00000000;
      case (AVS_ADDRESS)
        ckc_pkg::CKC_REG_CTRL: begin
          rdata_reg[ckc_pkg::CKC_CTRL_MODE_LSB +: 3] <= mode_reg;
          rdata_reg[ckc_pkg::CKC_CTRL_INTEN_BIT] <= int_en_reg;
        end
        ckc_pkg::CKC_REG_STATUS: begin
          rdata_reg[ckc_pkg::CKC_ST_STATE_LSB +: 3] <= state_reg;
          rdata_reg[ckc_pkg::CKC_ST_SRC_LSB +: 3] <= SOURCE_KIND;
          rdata_reg[ckc_pkg::CKC_ST_SWING_BIT] <= FULL_SWING;
          rdata_reg[ckc_pkg::CKC_ST_RANGE_LSB +: 2] <= OSC_RANGE;
          rdata_reg[ckc_pkg::CKC_ST_GATE_LSB +: 5] <= CLOCK_ENABLES;
          rdata_reg[ckc_pkg::CKC_ST_RSTN_BIT] <= INTERNAL_RESET_N;
        end
        ckc_pkg::CKC_REG_FUSE: begin
          rdata_reg[ckc_pkg::CKC_FU_CLOCK_SOURCE_SELECT_FUSES_LSB +: 4] <= fuse_reg.clock_source_select_fuses;
          rdata_reg[ckc_pkg::CKC_FU_SUT_LSB +: 2] <= fuse_reg.startup_time_fuses;
          rdata_reg[ckc_pkg::CKC_FU_OPT_BIT] <= fuse_reg.opt;
        end
        default: rdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign AVS_READDATA = rdata_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  AST_CORE_HELD: assert property (!INTERNAL_RESET_N |-> !CLOCK_ENABLES.core)
    else $error("Core clock running during internal reset");
  AST_FLASH_FOLLOWS: assert property (CLOCK_ENABLES.flash == CLOCK_ENABLES.core)
    else $error("Program memory clock differs from core clock");
  AST_ASY_SAVE: assert property (state_reg == ckc_pkg::CKC_ST_SLEEP &&
      mode_reg == ckc_pkg::CKC_SLP_PSAVE |-> CLOCK_ENABLES.asy && !CLOCK_ENABLES.core)
    else $error("Async timer clock stopped in power-save");
  AST_CONV_NR: assert property (state_reg == ckc_pkg::CKC_ST_SLEEP &&
      mode_reg == ckc_pkg::CKC_SLP_ADCNR |-> CLOCK_ENABLES.conv && !CLOCK_ENABLES.periph)
    else $error("Converter clock wrong in noise reduction");
  AST_PDOWN_ALL_OFF: assert property (state_reg == ckc_pkg::CKC_ST_SLEEP &&
      mode_reg == ckc_pkg::CKC_SLP_PDOWN |-> CLOCK_ENABLES == '0)
    else $error("Clock running in power-down");
  AST_LOWF_DECODE: assert property (fuse_reg.clock_source_select_fuses == ckc_pkg::CKC_CLOCK_SOURCE_SELECT_FUSES_LOWF
      |-> SOURCE_KIND == ckc_pkg::CKC_SRC_LOWF)
    else $error("Low-frequency crystal code misdecoded");
  AST_SWING: assert property (SOURCE_KIND == ckc_pkg::CKC_SRC_XTAL && !fuse_reg.opt
      |-> FULL_SWING && OSC_RANGE == 2'h3)
    else $error("Programmed option fuse not full swing");
  AST_XTAL_258: assert property (SOURCE_KIND == ckc_pkg::CKC_SRC_XTAL &&
      !fuse_reg.clock_source_select_fuses[0] && fuse_reg.startup_time_fuses == ckc_pkg::CKC_SUT_01
      |-> timing.su_ck == ckc_pkg::CKC_SU_258CK && timing.rd == ckc_pkg::CKC_RD_LONG)
    else $error("258 clock long option wrong");
  AST_XTAL_1K: assert property (SOURCE_KIND == ckc_pkg::CKC_SRC_XTAL &&
      fuse_reg.clock_source_select_fuses[0] && fuse_reg.startup_time_fuses == ckc_pkg::CKC_SUT_00
      |-> timing.su_ck == ckc_pkg::CKC_SU_1KCK && timing.rd == ckc_pkg::CKC_RD_LONG)
    else $error("1K clock long option wrong");
  AST_XTAL_16K: assert property (SOURCE_KIND == ckc_pkg::CKC_SRC_XTAL &&
      fuse_reg.clock_source_select_fuses[0] && fuse_reg.startup_time_fuses == ckc_pkg::CKC_SUT_01
      |-> timing.su_ck == 16'(P_SU_16K) && timing.rd == ckc_pkg::CKC_RD_NONE)
    else $error("16K clock option wrong");
  AST_RST_ORDER: assert property (CE && state_reg == ckc_pkg::CKC_ST_RSTDLY && cnt_done
      |=> state_reg == ckc_pkg::CKC_ST_STARTUP && !INTERNAL_RESET_N)
    else $error("Reset delay not followed by start-up count");
  AST_SHORT_DLY: assert property ($rose(state_reg == ckc_pkg::CKC_ST_STARTUP) &&
      timing.rd == ckc_pkg::CKC_RD_SHORT
      |-> $past(cnt_reg) == 17'(P_RST_SHORT - 1))
    else $error("Short reset delay count wrong");
  AST_WAKE_COUNT: assert property (state_reg == ckc_pkg::CKC_ST_SLEEP && CE && wake_sync &&
      mode_reg == ckc_pkg::CKC_SLP_PDOWN |=> state_reg == ckc_pkg::CKC_ST_WAKE)
    else $error("Power-down wake skipped start-up count");
  AST_ASYNC_INT: assert property (int_en_reg && EXT_INT_PIN |-> ASYNC_WAKE)
    else $error("Async interrupt not recognised");
  AST_TWI_ASYNC: assert property (!CLOCK_ENABLES.periph && TWO_WIRE_ADDR_MATCH
      |-> ASYNC_WAKE)
    else $error("Address match not recognised with peripherals stopped");
  AST_AVS_ACK: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CE
      |=> !AVS_WAITREQUEST)
    else $error("Avalon wait exceeded one cycle");

  COV_RUN: cover property ($rose(state_reg == ckc_pkg::CKC_ST_RUN));
  COV_DEEP_WAKE: cover property (state_reg == ckc_pkg::CKC_ST_WAKE ##1
      state_reg == ckc_pkg::CKC_ST_RUN);
  COV_IDLE: cover property (state_reg == ckc_pkg::CKC_ST_SLEEP &&
      mode_reg == ckc_pkg::CKC_SLP_IDLE);
  COV_READ: cover property (AVS_READ && !AVS_WAITREQUEST);

endmodule : ckc_top
`default_nettype wire

// ### clock_source_and_startup_control_bench.sv
// Self-checking bench for clock source and start-up control
`timescale 1ns/1ps
`default_nettype none
module clock_source_and_startup_control_bench;
  localparam int RS = 4;
  localparam int RL = 8;
  localparam int S16 = 6;
  // Periods in core clocks; watchdog kept slower than CLK/3
  localparam int SP = 4;
  localparam int WP = 16;
  typedef struct {logic [6:0] f; logic [2:0] src; logic [1:0] rg; int m; int n;} ckc_row_s;
  ckc_row_s rows [14] = '{
    '{7'h4A, 3'h0, 2'h0, 258, RS}, '{7'h5C, 3'h0, 2'h1, 258, RL},
    '{7'h6E, 3'h0, 2'h2, 1024, 0}, '{7'h7E, 3'h0, 2'h2, 1024, RS},
    '{7'h4B, 3'h0, 2'h0, 1024, RL}, '{7'h5D, 3'h0, 2'h1, S16, 0},
    '{7'h6F, 3'h0, 2'h2, S16, RS}, '{7'h3F, 3'h0, 2'h3, S16, RL},
    '{7'h49, 3'h1, 2'h0, 1024, RS}, '{7'h48, 3'h2, 2'h0, 18, 0},
    '{7'h75, 3'h2, 2'h0, 6, RS}, '{7'h54, 3'h3, 2'h0, 6, RS},
    '{7'h61, 3'h3, 2'h0, 6, RL}, '{7'h40, 3'h4, 2'h0, 6, 0}};
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic CE = 1'b1;
  logic [1:0] AVS_ADDRESS = 2'h0;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic [3:0] CLOCK_SOURCE_SELECT_FUSES = 4'h1;
  logic [1:0] STARTUP_TIME_FUSES = 2'h2;
  logic OSCILLATOR_OPTION_FUSE = 1'b1;
  wire logic SOURCE_OSC_PIN;
  wire logic WATCHDOG_OSC_PIN;
  logic WAKE_PIN = 1'b0;
  logic EXT_INT_PIN = 1'b0;
  logic TWO_WIRE_ADDR_MATCH = 1'b0;
  logic ASYNC_WAKE;
  logic INTERNAL_RESET_N;
  logic FULL_SWING;
  logic [1:0] OSC_RANGE;
  ckc_pkg::ckc_gate_s CLOCK_ENABLES;
  ckc_pkg::ckc_src_e SOURCE_KIND;
  int mismatches = 0;
  int total_checks = 0;
  bit bad = 0;
  int c;
  int e;
  logic [31:0] q;
  logic [2:0] md;
  initial begin
    forever #20 CLK = ~CLK;
  end
  ckc_osc_model #(.SRC_HALF_NS(SP * 20), .WDT_HALF_NS(WP * 20)) i_osc (
    .src_osc(SOURCE_OSC_PIN), .wdt_osc(WATCHDOG_OSC_PIN));
  ckc_top #(.P_RST_SHORT(RS), .P_RST_LONG(RL), .P_SU_16K(S16), .P_SU_32K(7)) i_dut (
    .CLK, .RSTN, .CE, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA,
    .AVS_WAITREQUEST, .CLOCK_SOURCE_SELECT_FUSES, .STARTUP_TIME_FUSES, .OSCILLATOR_OPTION_FUSE,
    .SOURCE_OSC_PIN, .WATCHDOG_OSC_PIN, .WAKE_PIN, .EXT_INT_PIN, .TWO_WIRE_ADDR_MATCH,
    .ASYNC_WAKE, .INTERNAL_RESET_N, .CLOCK_ENABLES, .SOURCE_KIND, .FULL_SWING, .OSC_RANGE);
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  // Waitrequest sampled at the rising edge that completes the access
  task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_READ <= ~w;
    AVS_WRITE <= w;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    @(posedge CLK);
  endtask : bus
  task automatic boot(input logic [6:0] f);
    {OSCILLATOR_OPTION_FUSE, STARTUP_TIME_FUSES, CLOCK_SOURCE_SELECT_FUSES} <= f;
    RSTN <= 1'b0;
    repeat (8) @(posedge CLK);
    RSTN <= 1'b1;
    c = 0;
    do begin
      @(negedge CLK);
      c++;
      if (INTERNAL_RESET_N !== 1'b1 && CLOCK_ENABLES !== 5'h0) bad = 1;
    end while (INTERNAL_RESET_N !== 1'b1 && c < 9000);
    @(posedge CLK);
  endtask : boot
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (60000) @(posedge CLK);
    mismatches++;
    summarize();
  end
  initial begin
    for (int i = 0; i < 14; i++) begin
      boot(rows[i].f);
      e = rows[i].n * WP + rows[i].m * SP;
      chk("delay", 1, c + 24 >= e && c <= e + 30);
      chk("hold", 0, bad);
      chk("kind", rows[i].src, SOURCE_KIND);
      chk("swing", !rows[i].f[6], FULL_SWING);
      chk("range", rows[i].rg, OSC_RANGE);
      chk("enables", 5'h1F, CLOCK_ENABLES);
      bus(1'b0, ckc_pkg::CKC_REG_FUSE, 32'h0);
      chk("fuse", rows[i].f, q);
      $display("row %0d done", i);
    end
    RSTN <= 1'b0;
    repeat (3) @(posedge CLK);
    @(negedge CLK);
    chk("ship kind", ckc_pkg::CKC_SRC_INTRC, SOURCE_KIND);
    chk("ship swing", 0, FULL_SWING);
    chk("rst hold", 0, {INTERNAL_RESET_N, CLOCK_ENABLES});
    chk("rst data", 0, AVS_READDATA);
    $display("reset test done");
    @(posedge CLK);
    boot(7'h4B);
    bus(1'b1, ckc_pkg::CKC_REG_CTRL, 32'h17);
    bus(1'b1, 2'h3, 32'hFFFFFFFF);
    bus(1'b0, 2'h3, 32'h0);
    chk("unmapped", 0, q);
    bus(1'b0, ckc_pkg::CKC_REG_CTRL, 32'h0);
    chk("ctrl", 32'h17, q);
    EXT_INT_PIN <= 1'b1;
    @(negedge CLK);
    chk("ext int", 1, ASYNC_WAKE);
    @(posedge CLK);
    bus(1'b1, ckc_pkg::CKC_REG_CTRL, 32'h0);
    chk("ext masked", 0, ASYNC_WAKE);
    EXT_INT_PIN <= 1'b0;
    $display("register test done");
    // Enable low must freeze the bus answer
    CE <= 1'b0;
    AVS_ADDRESS <= ckc_pkg::CKC_REG_STATUS;
    AVS_READ <= 1'b1;
    repeat (4) @(posedge CLK);
    chk("frozen", 1, AVS_WAITREQUEST);
    CE <= 1'b1;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    @(posedge CLK);
    chk("status", 32'h0000FC03, q);
    $display("enable test done");
    for (int i = 0; i < 6; i++) begin
      md = modes[i];
      bus(1'b1, ckc_pkg::CKC_REG_CTRL, {28'h0, 1'b1, md});
      c = 0;
      do begin @(negedge CLK); c++; end while (CLOCK_ENABLES.core !== 1'b0 && c < 20);
      chk("core", 0, {CLOCK_ENABLES.core, CLOCK_ENABLES.flash});
      if (md == ckc_pkg::CKC_SLP_ADCNR) chk("conv", 1, {CLOCK_ENABLES.periph, CLOCK_ENABLES.conv});
      if (md == ckc_pkg::CKC_SLP_PSAVE) chk("asy", 1, CLOCK_ENABLES.asy);
      @(posedge CLK);
      if (md == ckc_pkg::CKC_SLP_PDOWN) TWO_WIRE_ADDR_MATCH <= 1'b1;
      else WAKE_PIN <= 1'b1;
      @(negedge CLK);
      if (md == ckc_pkg::CKC_SLP_PDOWN) chk("two wire", 1, ASYNC_WAKE);
      c = 0;
      do begin @(negedge CLK); c++; end while (CLOCK_ENABLES.core !== 1'b1 && c < 6000);
      @(posedge CLK);
      WAKE_PIN <= 1'b0;
      TWO_WIRE_ADDR_MATCH <= 1'b0;
      chk("wake", md == 3'h2 || md == 3'h3, c > 1024 * SP - 40 && c < 1024 * SP + 40);
      chk("awake", 1, INTERNAL_RESET_N);
      $display("sleep mode %0d done", md);
    end
    summarize();
  end
endmodule : clock_source_and_startup_control_bench
`default_nettype wire
